// [design/sadc_regs.svh]
// Offsets, field positions, reset values and timing counts of the converter.
// Assumes an 8-bit register port with byte addresses inside a 256-byte page.
// Function
// [RQ1] Ten-bit result for every conversion
// [RQ2] Ten inputs, one converted per conversion
// [RQ3] Hardware start on selected trigger edges
// [RQ4] Software start by writing mode register
// [RQ5] Hardware conversion stops, one done pulse
// [RQ6] Software mode repeats, pulse each end
// [RQ7] Decide bits from MSB using comparator
// [RQ8] Copy approximation register after last bit
// [RQ9] Result 16 bits, left-justified, low six zero
// [RQ10] Result reloaded after every completed conversion
// [RQ11] Software reads result as 16-bit word
// [RQ12] Reset clears result register
// [RQ13] Software reads result before mode writes
// [RQ14] Hold sample for whole conversion
// [RQ15] First eight inputs double as digital ports
// [RQ16] Avoid port reads during low-channel conversion
// [RQ17] Trigger edge from bit 3 of enables
// [RQ18] Channel codes 0 to 9, others prohibited
// [RQ19] Bit 7 enables, bit 6 selects start
// [RQ20] Edge pair: none, falling, rising, both
// [RQ21] Software picks 144 to 576 clock periods; the code takes 143 to 572 (eleven phases of 13 to 52)
// [RQ22] Sampling phase then ten equal steps
// [RQ23] Clearing enable aborts without result update
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

`define SADC_ADDR_MODE     8'h80
`define SADC_ADDR_CHAN     8'h81
`define SADC_ADDR_RISE     8'h48
`define SADC_ADDR_FALL     8'h49
`define SADC_ADDR_RES_LO   8'h1E
`define SADC_ADDR_RES_HI   8'h1F

`define SADC_MODE_ENABLE   7
`define SADC_MODE_HWSTART  6
`define SADC_MODE_TIME_HI  5
`define SADC_MODE_TIME_LO  3
`define SADC_MODE_BOOST    0
`define SADC_TRIG_BIT      3
`define SADC_CHAN_MAX      4'h9

`define SADC_RESET_BYTE    8'h00
`define SADC_RESET_RESULT  16'h0000
`define SADC_RES_PAD       6

// Conversion times in main clock periods, selected by the time field.
`define SADC_TIME_144      10'h090
`define SADC_TIME_576      10'h240
`define SADC_TIME_480      10'h1E0
`define SADC_TIME_384      10'h180
// Each of the ten steps takes one eleventh; sampling gets the first share.
`define SADC_PHASES        10'h00B

`endif

// [design/sadc_pkg.sv]
// Types shared by the converter control modules.
// Assumes the constants header is included where offsets are needed.
package sadc_pkg;
    typedef enum logic [1:0]
    {
        SADC_IDLE   = 2'b00,
        SADC_SAMPLE = 2'b01,
        SADC_STEP   = 2'b10
    } sadc_state_t;
endpackage

// [design/sadc_trig_if.sv]
// Interface carrying trigger configuration and start event between modules.
// Assumes both ends run on the same clock.
interface sadc_trig_if;
    logic rise_en;
    logic fall_en;
    logic start;
    modport ctrl (output rise_en, output fall_en, input start);
    modport det  (input rise_en, input fall_en, output start);
endinterface

// [design/sadc_trig_det.sv]
// Edge detector for the external trigger pin.
// Assumes the pin is asynchronous and is synchronised here.
module sadc_trig_det
    import sadc_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    input  wire logic  pin_i,
    sadc_trig_if.det   trig
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    wire  rise_seen;
    wire  fall_seen;

    // Two stages of synchronisation, then one stage to remember the level.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end
        else
        begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    // Both bits clear leaves the pin ignored entirely.
    assign rise_seen  = sync2_reg & ~prev_reg & trig.rise_en; // [RQ20]
    assign fall_seen  = ~sync2_reg & prev_reg & trig.fall_en; // [RQ20]
    assign trig.start = rise_seen | fall_seen; // [RQ3]
endmodule

// [design/sadc_control.sv]
// Control logic of the ten-bit successive-approximation converter.
// Assumes an 8-bit register port on the system clock and an analog macro
// that answers the comparator within one clock of a tap change.
`include "sadc_regs.svh"
module sadc_control
    import sadc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        trigger_pin_i,
    input  wire logic        comparator_i,
    input  wire logic [7:0]  port_pins_i,
    output logic      [9:0]  tap_o,
    output logic      [3:0]  channel_o,
    output logic             hold_o,
    output logic             booster_en_o,
    output logic      [7:0]  port_data_o,
    output logic             conversion_done_irq_o
);
    sadc_trig_if trig ();

    logic [7:0]   mode_reg;
    logic [3:0]   chan_reg;
    logic [7:0]   rise_reg;
    logic [7:0]   fall_reg;
    logic [15:0]  result_reg;
    logic [9:0]   approx_reg;
    logic [9:0]   approx_next;
    logic [9:0]   bit_reg;
    logic [9:0]   cnt_reg;
    sadc_state_t  state_reg;
    sadc_state_t  state_next;
    logic         done_reg;
    logic [7:0]   psync1_reg;
    logic [7:0]   psync2_reg;
    logic [7:0]   rdata_reg;

    wire       enabled;
    wire       hw_mode;
    wire [9:0] phase_len;
    wire       phase_end;
    wire       last_bit;
    wire       sw_start;
    wire       go;
    wire       abort;
    wire       finish;
    wire       wr_mode;
    wire [7:0] rdata_next;

    // Length of one phase for the selected conversion time; prohibited codes
    // fall back to the longest time so the converter is never too fast.
    function automatic logic [9:0] phase_of(input logic [2:0] sel);
        logic [9:0] total;
        total = `SADC_TIME_576;
        case (sel)
            3'h0:    total = `SADC_TIME_144;
            3'h4:    total = `SADC_TIME_576;
            3'h5:    total = `SADC_TIME_480;
            3'h6:    total = `SADC_TIME_384;
            default: total = `SADC_TIME_576;
        endcase
        phase_of = total / `SADC_PHASES;
    endfunction

    // Address match, used by both the write and the read paths.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    sadc_trig_det u_trig
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i (trigger_pin_i),
        .trig  (trig)
    );

    // Field decode of the mode register and trigger edge selection.
    assign enabled      = mode_reg[`SADC_MODE_ENABLE]; // [RQ19]
    assign hw_mode      = mode_reg[`SADC_MODE_HWSTART]; // [RQ19]
    assign trig.rise_en = enabled & hw_mode & rise_reg[`SADC_TRIG_BIT]; // [RQ17]
    assign trig.fall_en = enabled & hw_mode & fall_reg[`SADC_TRIG_BIT]; // [RQ17]
    assign phase_len    = phase_of(mode_reg[`SADC_MODE_TIME_HI:`SADC_MODE_TIME_LO]);
    assign phase_end    = (cnt_reg == phase_len - 10'h001); // [RQ22]
    assign last_bit     = bit_reg[0];
    assign wr_mode      = wr_i & hit(addr_i, `SADC_ADDR_MODE);

    // Software start runs whenever enabled without hardware start; a
    // hardware conversion only begins on a qualified trigger edge.
    assign sw_start = enabled & ~hw_mode; // [RQ4]
    assign go       = (state_reg == SADC_IDLE) & (sw_start | trig.start); // [RQ3]
    assign abort    = ~enabled; // [RQ23]
    assign finish   = (state_reg == SADC_STEP) & phase_end & last_bit & enabled;

    // One comparison: keep the trial bit if the input is at or above the tap and
    // set the next lower bit as the new trial.
    always_comb
    begin
        approx_next = approx_reg;
        if (!comparator_i)
        begin
            approx_next = approx_reg & ~bit_reg; // [RQ7]
        end
        approx_next = approx_next | (bit_reg >> 1);
    end

    // Sequencer state selection.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SADC_IDLE:
            begin
                if (go)
                begin
                    state_next = SADC_SAMPLE;
                end
            end
            SADC_SAMPLE:
            begin
                if (abort)
                begin
                    state_next = SADC_IDLE;
                end
                else if (phase_end)
                begin
                    state_next = SADC_STEP; // [RQ22]
                end
            end
            SADC_STEP:
            begin
                if (abort)
                begin
                    state_next = SADC_IDLE; // [RQ23]
                end
                else if (phase_end && last_bit)
                begin
                    // Hardware start stops; software start restarts at once.
                    state_next = hw_mode ? SADC_IDLE : SADC_SAMPLE; // [RQ5] [RQ6]
                end
            end
            default:
            begin
                state_next = SADC_IDLE;
            end
        endcase
    end

    // Sequencer registers and the approximation register.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg  <= SADC_IDLE;
            cnt_reg    <= 10'h000;
            approx_reg <= 10'h000;
            bit_reg    <= 10'h000;
        end
        else
        begin
            state_reg <= state_next;
            if (state_next != state_reg || phase_end)
            begin
                cnt_reg <= 10'h000;
            end
            else
            begin
                cnt_reg <= cnt_reg + 10'h001;
            end
            if (state_reg == SADC_SAMPLE && phase_end)
            begin
                approx_reg <= 10'h200; // [RQ7]
                bit_reg    <= 10'h200;
            end
            else if (state_reg == SADC_STEP && phase_end)
            begin
                approx_reg <= approx_next; // [RQ1]
                bit_reg    <= bit_reg >> 1;
            end
        end
    end

    // Result transfer and the done pulse, one clock per finished conversion.
    // An aborted conversion never reaches finish, so the result stays put.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            result_reg <= `SADC_RESET_RESULT; // [RQ12]
            done_reg   <= 1'b0;
        end
        else
        begin
            done_reg <= finish; // [RQ5] [RQ6]
            if (finish)
            begin
                // Final bit decision is folded in as it is copied.
                result_reg <= {approx_next, {`SADC_RES_PAD{1'b0}}}; // [RQ8] [RQ9] [RQ10]
            end
        end
    end

    // Register writes. Channel codes above nine are refused, keeping the
    // previous channel so the multiplexer never sees a prohibited select.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode_reg <= `SADC_RESET_BYTE;
            chan_reg <= 4'h0;
            rise_reg <= `SADC_RESET_BYTE;
            fall_reg <= `SADC_RESET_BYTE;
        end
        else if (wr_i)
        begin
            if (wr_mode)
            begin
                mode_reg <= wdata_i;
            end
            if (hit(addr_i, `SADC_ADDR_CHAN) && wdata_i[3:0] <= `SADC_CHAN_MAX)
            begin
                chan_reg <= wdata_i[3:0]; // [RQ18]
            end
            if (hit(addr_i, `SADC_ADDR_RISE))
            begin
                rise_reg <= {2'h0, wdata_i[5:0]};
            end
            if (hit(addr_i, `SADC_ADDR_FALL))
            begin
                fall_reg <= {2'h0, wdata_i[5:0]};
            end
        end
    end

    // Digital port path for the shared pins, synchronised twice.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            psync1_reg  <= 8'h00;
            psync2_reg  <= 8'h00;
            port_data_o <= 8'h00;
        end
        else
        begin
            psync1_reg <= port_pins_i;
            psync2_reg <= psync1_reg;
            // The pin that feeds the converter reads zero as a digital input.
            for (int i = 0; i < 8; i++)
            begin
                port_data_o[i] <= (chan_reg == 4'(i)) ? 1'b0 : psync2_reg[i]; // [RQ15]
            end
        end
    end

    // Read multiplexer; unmapped addresses answer zero. The result halves
    // are meant to be fetched together as one 16-bit access.
    assign rdata_next =
        hit(addr_i, `SADC_ADDR_MODE)   ? mode_reg :
        hit(addr_i, `SADC_ADDR_CHAN)   ? {4'h0, chan_reg} :
        hit(addr_i, `SADC_ADDR_RISE)   ? rise_reg :
        hit(addr_i, `SADC_ADDR_FALL)   ? fall_reg :
        hit(addr_i, `SADC_ADDR_RES_LO) ? result_reg[7:0] : // [RQ9]
        hit(addr_i, `SADC_ADDR_RES_HI) ? result_reg[15:8] : 8'h00;

    // Read data registered one clock after the strobe.
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_reg <= 8'h00;
        end
        else if (rd_i)
        begin
            rdata_reg <= rdata_next;
        end
    end

    // Analog-side controls; hold stays up from sample end to last decision.
    assign rdata_o               = rdata_reg;
    assign tap_o                 = approx_reg;
    assign channel_o             = chan_reg; // [RQ2]
    assign hold_o                = (state_reg == SADC_STEP); // [RQ14]
    assign booster_en_o          = mode_reg[`SADC_MODE_BOOST];
    assign conversion_done_irq_o = done_reg;
endmodule

// [testbench/sadc_control_sva.sv]
// Port-level checks of the converter control block.
// Assumes one clock domain and an active-high asynchronous reset.
`include "sadc_regs.svh"
module sadc_control_sva
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] addr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [9:0] tap_o,
    input wire logic [3:0] channel_o,
    input wire logic       hold_o,
    input wire logic [7:0] port_data_o,
    input wire logic       conversion_done_irq_o
);
    timeunit 1ns;
    timeprecision 100ps;
    wire irq = conversion_done_irq_o;

    // Every check runs on the system clock and pauses in reset.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_irq_pulse: assert property (irq |=> !irq)
        else $error("done pulse wider than one cycle");
    chk_irq_after: assert property (
        irq |-> $past(hold_o) || $past(hold_o, 2))
        else $error("done pulse without a finished step phase");
    chk_hold_steps: assert property ($rose(hold_o) |-> hold_o[*8])
        else $error("hold released too early");
    chk_sample_first: assert property (
        $rose(hold_o) |-> !$past(hold_o, 8))
        else $error("sampling phase too short");
    chk_tap_msb: assert property ($rose(hold_o) |-> tap_o == 10'h200)
        else $error("first trial is not the top bit");
    chk_chan_legal: assert property (channel_o <= `SADC_CHAN_MAX)
        else $error("prohibited channel code selected");
    chk_port_mask: assert property (
        ($stable(channel_o) && channel_o < 4'h8)
        |-> port_data_o[channel_o[2:0]] == 1'b0)
        else $error("selected analog pin visible on port");
    chk_rdata_stands: assert property (
        !$past(rd_i) |-> $stable(rdata_o))
        else $error("read data changed without a read");
    chk_res_low_zero: assert property (
        (rd_i && addr_i == `SADC_ADDR_RES_LO) |=> rdata_o[5:0] == 6'h00)
        else $error("result low bits not zero");

    cover property ($rose(irq));
    cover property ($rose(hold_o));
    cover property (rd_i && addr_i == `SADC_ADDR_RES_HI);
endmodule

// [testbench/sadc_analog_model.sv]
// Analog side: the selected input level and the comparator behind the tap.
// Assumes the bench supplies the level of the selected input.
module sadc_analog_model
(
    input  wire logic       clk_i,
    input  wire logic [9:0] level_i,
    input  wire logic [9:0] tap_i,
    input  wire logic       hold_i,
    output logic            comparator_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] held_reg;
    logic       noise_reg = 1'b0;

    // The level is frozen while held; outside hold the output is noise.
    always_ff @(posedge clk_i)
    begin
        if (!hold_i)
            held_reg <= level_i;
        noise_reg <= ~noise_reg;
    end

    // Input at or above the tap reads as one.
    assign comparator_o = hold_i ? (held_reg >= tap_i) : noise_reg;
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the converter control block.
// Assumes the analog model answers on the tap and comparator ports.
`include "sadc_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk_i = 1'b0;
    logic [7:0] pins = 8'hA5;
    logic       rst_i = 1'b1;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       trig = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] rdata_o;
    logic [9:0] tap_o;
    logic [9:0] level = 10'h000;
    logic [3:0] channel_o;
    logic [7:0] port_data_o;
    logic       hold_o;
    logic       booster_en_o;
    logic       irq;
    logic       comp;
    int         errors = 0;
    int         checks_done = 0;
    int         irq_cnt = 0;
    int         cycles = 0;

    sadc_control i_dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .trigger_pin_i(trig), .comparator_i(comp), .port_pins_i(pins),
        .tap_o(tap_o), .channel_o(channel_o), .hold_o(hold_o),
        .booster_en_o(booster_en_o), .port_data_o(port_data_o),
        .conversion_done_irq_o(irq));
    sadc_analog_model i_analog (.clk_i(clk_i), .level_i(level),
        .tap_i(tap_o), .hold_i(hold_o), .comparator_o(comp));

    // Free-running 40 MHz clock.
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end

    // Count done pulses; a hung run is cut off as a failure.
    always @(posedge clk_i)
    begin
        cycles++;
        if (irq === 1'b1)
            irq_cnt++;
        if (cycles >= 20000)
        begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) #1;
        wr_i = 1'b1;
        addr_i = a;
        wdata_i = d;
        @(posedge clk_i) #1;
        wr_i = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i) #1;
        rd_i = 1'b1;
        addr_i = a;
        @(posedge clk_i) #1;
        rd_i = 1'b0;
        d = rdata_o;
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Bounded wait for a done-pulse count.
    task automatic wait_irq(input int n);
        repeat (1000) if (irq_cnt < n) @(posedge clk_i);
        #1;
        check(irq_cnt[15:0], n[15:0]);
    endtask

    // The result is read as a word: low byte, then high byte.
    task automatic chk_result(input logic [9:0] v);
        logic [7:0] d;
        rd(`SADC_ADDR_RES_LO, d);
        check(d, {v[1:0], 6'h00});
        rd(`SADC_ADDR_RES_HI, d);
        check(d, v[9:2]);
    endtask

    initial
    begin
        logic [7:0] d;
        logic [9:0] lv [3] = '{10'h3FF, 10'h000, 10'h2B7};
        int         base;
        repeat (10) @(posedge clk_i);
        #1 rst_i = 1'b0;
        chk_result(10'h000);
        rd(8'h55, d);
        check(d, 8'h00);
        wr(`SADC_ADDR_RISE, 8'hFF);
        rd(`SADC_ADDR_RISE, d);
        check(d, 8'h3F);
        $display("test reset and map done");
        // Sweep codes 0 to 10; the prohibited code 10 must leave channel 9.
        for (int ch = 0; ch < 11; ch++)
        begin
            wr(`SADC_ADDR_CHAN, 8'(ch));
            wait_cycles(2);
            check(channel_o, (ch < 10) ? ch : 9);
            // Ports are only read while idle, never during a conversion.
            if (ch < 8)
                check(port_data_o, pins & ~(8'h01 << ch));
        end
        $display("test channels done");
        // Software start repeats; two pulses settle a new level.
        wr(`SADC_ADDR_CHAN, 8'h03);
        wr(`SADC_ADDR_MODE, 8'h81);
        wait_cycles(2);
        check(booster_en_o, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            level = lv[i];
            base = irq_cnt;
            wait_irq(base + 2);
            chk_result(lv[i]);
        end
        // Stopping mid-conversion must leave the old result.
        wait_cycles(40);
        wr(`SADC_ADDR_MODE, 8'h01);
        level = 10'h111;
        base = irq_cnt;
        wait_cycles(400);
        check(irq_cnt - base, 16'h0000);
        chk_result(10'h2B7);
        $display("test software start done");
        // Hardware start for each edge setting; each enabled edge converts once.
        level = 10'h1A5;
        wr(`SADC_ADDR_CHAN, 8'h09);
        for (int e = 0; e < 4; e++)
        begin
            wr(`SADC_ADDR_RISE, e[1] ? 8'h08 : 8'h00);
            wr(`SADC_ADDR_FALL, e[0] ? 8'h08 : 8'h00);
            wr(`SADC_ADDR_MODE, 8'hC1);
            base = irq_cnt;
            trig = 1'b1;
            wait_cycles(300);
            trig = 1'b0;
            wait_cycles(300);
            check(irq_cnt - base, e[1] + e[0]);
            // The result is fetched before the next mode write.
            chk_result((e == 0) ? 10'h2B7 : 10'h1A5);
        end
        chk_result(10'h1A5);
        $display("test hardware start done");
        end_sim();
    end
endmodule

bind sadc_control sadc_control_sva i_sva (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tap_o(tap_o),
    .channel_o(channel_o), .hold_o(hold_o), .port_data_o(port_data_o),
    .conversion_done_irq_o(conversion_done_irq_o));
